// *** hw/watchdog_timer.sv ***
// watchdog timer with apb register access
//
// How it works
// - config bit picks source clock: sub clock or core clock divided by four.
// - config bit picks sub clock from low-speed crystal or low-speed rc.
// - control bits 6..4 set period of 256 to 32768 source clocks.
// - stops only when config disables and key field equals 1010.
// - control resets to key 1010, select 111, keep bit 0.
// - while disabled, watchdog instructions do nothing.
// - overflow in normal running forces device reset and sets timeout flag.
// - overflow in sleep or idle sets flag, resets only pc and stack.
// - counter cleared by reset pin low, clear instructions or halt.
// - config bit selects single clear or paired clear scheme.
// - single mode: each single clear instruction clears the counter.
// - paired mode: only a clear differing from the previous one clears.
// - control bit 7 keeps core clock running in idle when set.
// - divided core clock source stops in sleep and idle with core off.
// - core-clock source follows switch to the low-speed system clock.
// - sub clock and source clock run only while watchdog is enabled.
// - idle with core off: sub clock keeps counting, core clock stops.
// - power-down flag cleared by power-up and clears, set by halt.
// - timeout in run leaves pd flag; in idle or sleep both flags 1.
//
// Register access over APB and the address map were chosen for this implementation.
module watchdog_timer (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ext_reset_n_i,
  input wire logic low_speed_crystal_tick_i,
  input wire logic low_speed_rc_tick_i,
  input wire logic core_clock_tick_i,
  input wire logic idle_select_i,
  output logic device_reset_o,
  output logic pc_stack_reset_o,
  output logic core_clock_run_o,
  output logic sub_clock_run_o,
  output logic [1:0] power_mode_o
);
  logic [7:0] control_q;
  logic [4:0] config_q;
  logic timeout_flag_q;
  logic powerdown_flag_q;
  wdt_pkg::power_mode_t mode_q;
  wdt_pkg::last_clear_t last_q;
  logic [1:0] div_q;
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic dev_rst_q;
  logic pc_rst_q;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [4:0] cmd;
  logic cfg_enable;
  logic use_sub;
  logic use_lxt;
  logic paired;
  logic wdt_enabled;
  logic sub_tick;
  logic sys_tick;
  logic src_tick;
  logic src_running;
  logic sw_clear;
  logic do_halt;
  logic do_single;
  logic do_first;
  logic do_second;
  logic asleep;

  wdt_tick_if tk ();

  wdt_prescale_counter u_counter (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tk(tk)
  );

  // apb decode: zero-wait-state slave, every access completes in its access phase
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      wdt_pkg::CONTROL_OFFSET,
      wdt_pkg::CONFIG_OFFSET,
      wdt_pkg::STATUS_OFFSET,
      wdt_pkg::COMMAND_OFFSET: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  // unmapped address answers with an error, no side effect
  assign pslverr_o = psel_i && penable_i && !mapped;

  assign cfg_enable = config_q[wdt_pkg::CFG_EN_BIT];
  assign use_sub = config_q[wdt_pkg::CFG_SUB_BIT];
  assign use_lxt = config_q[wdt_pkg::CFG_LXT_BIT];
  assign paired = config_q[wdt_pkg::CFG_PAIR_BIT];
  // watchdog only stops with config disabled and the magic key present
  assign wdt_enabled = cfg_enable ||
    (control_q[wdt_pkg::KEY_MSB:wdt_pkg::KEY_LSB] != wdt_pkg::DISABLE_KEY);

  // command strobes; the instruction decoder reaches them as a register write
  assign cmd = (wr_en && paddr_i == wdt_pkg::COMMAND_OFFSET) ? pwdata_i[4:0] : 5'h00;
  assign do_halt = cmd[wdt_pkg::CMD_HALT_BIT] && mode_q == wdt_pkg::MODE_RUN;
  // instructions are no-ops while the watchdog is off
  assign do_single = cmd[wdt_pkg::CMD_SINGLE_BIT] && wdt_enabled && !paired;
  assign do_first = cmd[wdt_pkg::CMD_FIRST_BIT] && wdt_enabled && paired;
  assign do_second = cmd[wdt_pkg::CMD_SECOND_BIT] && wdt_enabled && paired;
  // paired scheme clears only on alternation; first ever clear counts
  assign sw_clear = do_single ||
    (do_first && last_q != wdt_pkg::CLR_FIRST) ||
    (do_second && last_q != wdt_pkg::CLR_SECOND);

  // sub clock comes from the crystal or the rc oscillator
  assign sub_tick = use_lxt ? low_speed_crystal_tick_i : low_speed_rc_tick_i;
  // core clock tick already reflects the high/low speed selection upstream
  assign core_clock_run_o = mode_q == wdt_pkg::MODE_RUN ||
    mode_q == wdt_pkg::MODE_IDLE_ON;
  assign sys_tick = core_clock_tick_i && core_clock_run_o && div_q == wdt_pkg::SYS_DIV_LAST;
  // sub clock powered only while the watchdog needs it
  assign sub_clock_run_o = wdt_enabled && use_sub;
  assign src_running = wdt_enabled && (use_sub || core_clock_run_o);
  assign src_tick = src_running && (use_sub ? sub_tick : sys_tick);
  assign asleep = mode_q != wdt_pkg::MODE_RUN;

  assign tk.tick = src_tick;
  assign tk.sel = control_q[wdt_pkg::SEL_MSB:wdt_pkg::SEL_LSB];
  // reset pin, clears and halt all restart the count
  assign tk.clear = !ext_reset_n_i || sw_clear || do_halt;

  // divide-by-four of the core clock ticks; frozen when the core clock stops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else if (core_clock_tick_i && core_clock_run_o) begin
      div_q <= div_q + 1'b1;
    end
  end

  // control register, restored to its power-on value by device resets
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      control_q <= wdt_pkg::CONTROL_RESET;
    end else if (!ext_reset_n_i || dev_rst_q) begin
      control_q <= wdt_pkg::CONTROL_RESET;
    end else if (wr_en && paddr_i == wdt_pkg::CONTROL_OFFSET) begin
      control_q <= pwdata_i[7:0];
    end
  end

  // configuration options latch; only power-on restores them
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_q <= wdt_pkg::CONFIG_RESET;
    end else if (wr_en && paddr_i == wdt_pkg::CONFIG_OFFSET) begin
      config_q <= pwdata_i[4:0];
    end
  end

  // memory of the last effective paired clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_q <= wdt_pkg::CLR_NONE;
    end else if (!ext_reset_n_i || dev_rst_q) begin
      last_q <= wdt_pkg::CLR_NONE;
    end else if (do_first) begin
      last_q <= wdt_pkg::CLR_FIRST;
    end else if (do_second) begin
      last_q <= wdt_pkg::CLR_SECOND;
    end
  end

  // power state: halt enters sleep/idle, wake or any reset returns to run
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_q <= wdt_pkg::MODE_RUN;
    end else if (!ext_reset_n_i || tk.overflow || cmd[wdt_pkg::CMD_WAKE_BIT]) begin
      mode_q <= wdt_pkg::MODE_RUN;
    end else if (do_halt) begin
      case ({idle_select_i, control_q[wdt_pkg::KEEP_BIT]})
        2'b11: mode_q <= wdt_pkg::MODE_IDLE_ON;
        2'b10: mode_q <= wdt_pkg::MODE_IDLE_OFF;
        default: mode_q <= wdt_pkg::MODE_SLEEP;
      endcase
    end
  end
  assign power_mode_o = mode_q;

  // time-out flag: overflow wins over the clearing halt or clear instruction
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timeout_flag_q <= 1'b0;
    end else if (tk.overflow) begin
      timeout_flag_q <= 1'b1;
    end else if (do_halt || sw_clear) begin
      timeout_flag_q <= 1'b0;
    end
  end

  // power-down flag: set by halt, cleared by clears, kept by any time-out
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      powerdown_flag_q <= 1'b0;
    end else if (tk.overflow) begin
      powerdown_flag_q <= powerdown_flag_q;
    end else if (do_halt) begin
      powerdown_flag_q <= 1'b1;
    end else if (sw_clear) begin
      powerdown_flag_q <= 1'b0;
    end
  end

  // reset requests: full reset when running, pc/stack only when asleep
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dev_rst_q <= 1'b0;
      pc_rst_q <= 1'b0;
    end else begin
      dev_rst_q <= tk.overflow && !asleep;
      pc_rst_q <= tk.overflow && asleep;
    end
  end
  assign device_reset_o = dev_rst_q;
  assign pc_stack_reset_o = pc_rst_q;

  // read mux; status shows the block's own state
  always_comb begin
    rdata_d = '0;
    case (paddr_i)
      wdt_pkg::CONTROL_OFFSET: rdata_d[7:0] = control_q;
      wdt_pkg::CONFIG_OFFSET: rdata_d[4:0] = config_q;
      wdt_pkg::STATUS_OFFSET: begin
        rdata_d[wdt_pkg::ST_TO_BIT] = timeout_flag_q;
        rdata_d[wdt_pkg::ST_PD_BIT] = powerdown_flag_q;
        rdata_d[wdt_pkg::ST_RUN_BIT] = src_running;
        rdata_d[5:4] = mode_q;
        rdata_d[16 +: wdt_pkg::CNT_W] = tk.count;
      end
      default: rdata_d = '0;
    endcase
  end

  // read data registered at the edge ending the setup phase
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prdata_q <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_q <= rdata_d;
    end
  end
  assign prdata_o = prdata_q;
endmodule

// *** hw/wdt_pkg.sv ***
// shared constants for the watchdog timer block
package wdt_pkg;
  // register map (byte addresses)
  localparam logic [11:0] CONTROL_OFFSET = 12'h000;
  localparam logic [11:0] CONFIG_OFFSET = 12'h004;
  localparam logic [11:0] STATUS_OFFSET = 12'h008;
  localparam logic [11:0] COMMAND_OFFSET = 12'h00C;
  // control register fields
  localparam int KEY_LSB = 0;
  localparam int KEY_MSB = 3;
  localparam int SEL_LSB = 4;
  localparam int SEL_MSB = 6;
  localparam int KEEP_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h7A;
  localparam logic [3:0] DISABLE_KEY = 4'hA;
  localparam logic [3:0] ADVISED_KEY = 4'h5;
  // config register fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_SUB_BIT = 1;
  localparam int CFG_LXT_BIT = 2;
  localparam int CFG_PAIR_BIT = 3;
  localparam int CFG_LOW_BIT = 4;
  localparam logic [4:0] CONFIG_RESET = 5'h03;
  // status register fields
  localparam int ST_TO_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_RUN_BIT = 2;
  // command register bits
  localparam int CMD_SINGLE_BIT = 0;
  localparam int CMD_FIRST_BIT = 1;
  localparam int CMD_SECOND_BIT = 2;
  localparam int CMD_HALT_BIT = 3;
  localparam int CMD_WAKE_BIT = 4;
  // counter
  localparam int CNT_W = 15;
  localparam int SYS_DIV = 4;
  localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);
  localparam int BASE_SHIFT = 8;
  // power state and paired-clear memory
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE_ON,
    MODE_IDLE_OFF,
    MODE_SLEEP
  } power_mode_t;
  typedef enum logic [1:0] {
    CLR_NONE,
    CLR_FIRST,
    CLR_SECOND
  } last_clear_t;
endpackage

// *** hw/wdt_prescale_counter.sv ***
// 15-bit up-counter with selectable overflow point
module wdt_prescale_counter (
  input wire logic clk_i,
  input wire logic rstn_i,
  wdt_tick_if.cnt tk
);
  logic [wdt_pkg::CNT_W-1:0] count_q;
  logic [wdt_pkg::CNT_W:0] limit;

  // 256 shifted left by the select code
  assign limit = (wdt_pkg::CNT_W+1)'(1) << (wdt_pkg::BASE_SHIFT + int'(tk.sel));
  // overflow when the next tick would reach the selected limit
  assign tk.overflow = tk.tick && ({1'b0, count_q} == limit - 1'b1);
  assign tk.count = count_q;

  // clear has priority; wraps to zero on overflow
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_q <= '0;
    end else if (tk.clear || tk.overflow) begin
      count_q <= '0;
    end else if (tk.tick) begin
      count_q <= count_q + 1'b1;
    end
  end
endmodule

// *** hw/wdt_tick_if.sv ***
// source-clock tick, clear and period select passed to the prescale counter
interface wdt_tick_if;
  logic tick;
  logic clear;
  logic [2:0] sel;
  logic overflow;
  logic [14:0] count;
  modport ctrl (output tick, output clear, output sel, input overflow, input count);
  modport cnt (input tick, input clear, input sel, output overflow, output count);
endinterface

// *** tb/tb.sv ***
// self-checking bench for the watchdog timer
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [32:0] v; logic [32:0] m;} note_t;
  logic clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rs = 32'h0000_0009;
  logic pready_o, pslverr_o, device_reset_o, pc_stack_reset_o, core_clock_run_o, sub_clock_run_o;
  logic ext_reset_n_i = 1'b1, idle_select_i = 1'b0;
  // bench-only: when set, sub clock ticks come from the crystal input instead of the rc input
  logic xtal = 1'b0;
  logic low_speed_crystal_tick_i = 1'b0, low_speed_rc_tick_i = 1'b0, core_clock_tick_i = 1'b0;
  logic [1:0] power_mode_o;
  int checks = 0;
  int mismatches = 0;
  note_t q[$];
  watchdog_timer uut (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .ext_reset_n_i, .low_speed_crystal_tick_i,
    .low_speed_rc_tick_i, .core_clock_tick_i, .idle_select_i, .device_reset_o,
    .pc_stack_reset_o, .core_clock_run_o, .sub_clock_run_o, .power_mode_o);
  always #10 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer plus an idle cycle, so psel never toggles within a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    {psel_i, penable_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic e, input logic [31:0] v,
    input logic [31:0] m);
    q.push_back('{{e, v}, {1'b1, m}});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse(input logic [1:0] k);
    q.push_back('{{31'h0000_0000, k}, {33{1'b1}}});
  endtask
  // n ticks on the selected input (core ticks are divided by four); the unused tick inputs get random values
  task automatic ticks(input int n, input logic core);
    repeat (n) begin
      rs = xs(rs);
      {low_speed_rc_tick_i, low_speed_crystal_tick_i, core_clock_tick_i} <=
        core ? {rs[2], rs[0], 1'b1} : {!xtal || rs[2], xtal || rs[0], rs[1]};
      @(posedge clk_i);
    end
    {low_speed_rc_tick_i, low_speed_crystal_tick_i, core_clock_tick_i} <= 3'h0;
    repeat (3) @(posedge clk_i);
    `CHK(q.size(), 0)
  endtask
  task automatic mode_chk(input logic [1:0] m, input logic c);
    @(posedge clk_i);
    `CHK(power_mode_o, m)
    `CHK(core_clock_run_o, c)
  endtask
  task automatic take(input logic [32:0] v);
    note_t n;
    n = (q.size() > 0) ? q.pop_front() : note_t'{33'h0_0000_0000, {33{1'b1}}};
    `CHK(v & n.m, n.v)
  endtask
  // watcher: read data and reset pulses are matched to the oldest note
  always @(posedge clk_i) begin
    if (rstn_i && psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
      take({pslverr_o, prdata_o});
    if (rstn_i && (device_reset_o | pc_stack_reset_o) !== 1'b0)
      take({31'h0000_0000, device_reset_o, pc_stack_reset_o});
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(wdt_pkg::CONTROL_OFFSET, 1'b0, 32'h0000_007A, 32'h0000_00FF);
    rd(wdt_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, 32'h0000_0033);
    rd(12'h010, 1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    ticks(255, 1'b0);
    pulse(2'b10);
    ticks(1, 1'b0);
    rd(wdt_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0001, 32'h0000_0033);
    // a device reset restores control, so the short period is set again
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    // paired scheme: a repeated clear must not restart the count
    wr(wdt_pkg::CONFIG_OFFSET, 32'h0000_000B);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0002);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0004);
    ticks(200, 1'b0);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0004);
    ticks(55, 1'b0);
    pulse(2'b10);
    ticks(1, 1'b0);
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0004);
    ticks(200, 1'b0);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0002);
    ticks(100, 1'b0);
    // sleep: halt clears, overflow only resets pc and stack
    wr(wdt_pkg::CONFIG_OFFSET, 32'h0000_0003);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0008);
    mode_chk(wdt_pkg::MODE_SLEEP, 1'b0);
    ticks(255, 1'b0);
    pulse(2'b01);
    ticks(1, 1'b0);
    rd(wdt_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0007, 32'h7FFF_0037);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    rd(wdt_pkg::STATUS_OFFSET, 1'b0, 32'h0000_0000, 32'h0000_0033);
    // disabled by config and key: a clear is ignored and the count freezes
    ticks(100, 1'b0);
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_000A);
    wr(wdt_pkg::CONFIG_OFFSET, 32'h0000_0002);
    `CHK(sub_clock_run_o, 1'b0)
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    ticks(300, 1'b0);
    rd(wdt_pkg::STATUS_OFFSET, 1'b0, 32'h0064_0000, 32'h7FFF_0037);
    // re-enabled by key alone, the count resumes where it froze
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    ticks(155, 1'b0);
    pulse(2'b10);
    ticks(1, 1'b0);
    // divided core clock source; phase of the divide is not pinned down
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    wr(wdt_pkg::CONFIG_OFFSET, 32'h0000_0001);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    pulse(2'b10);
    ticks(1030, 1'b1);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    // short period again, so a counting core source in idle would time out
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    idle_select_i <= 1'b1;
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0008);
    mode_chk(wdt_pkg::MODE_IDLE_OFF, 1'b0);
    ticks(1100, 1'b1);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0010);
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0085);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0008);
    mode_chk(wdt_pkg::MODE_IDLE_ON, 1'b1);
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0010);
    // reset pin clears the count and restores control; crystal-fed sub clock
    wr(wdt_pkg::CONFIG_OFFSET, 32'h0000_0007);
    xtal = 1'b1;
    wr(wdt_pkg::COMMAND_OFFSET, 32'h0000_0001);
    ticks(200, 1'b0);
    ext_reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    ext_reset_n_i <= 1'b1;
    @(posedge clk_i);
    rd(wdt_pkg::CONTROL_OFFSET, 1'b0, 32'h0000_007A, 32'h0000_00FF);
    wr(wdt_pkg::CONTROL_OFFSET, 32'h0000_0005);
    ticks(255, 1'b0);
    pulse(2'b10);
    ticks(1, 1'b0);
    results();
  end
  // hang guard, about twice the expected run
  initial begin
    #200000;
    mismatches++;
    results();
  end
endmodule

// *** tb/watchdog_timer_asserts.sv ***
// port-level checker for the watchdog timer, bound to its top module
module watchdog_timer_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic ext_reset_n_i,
  input wire logic device_reset_o,
  input wire logic pc_stack_reset_o,
  input wire logic core_clock_run_o,
  input wire logic [1:0] power_mode_o
);
  // only four aligned words are mapped
  wire logic bad_a = (paddr_i[11:4] != 8'h00) || (paddr_i[1:0] != 2'h0);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_ready_high: assert property (pready_o) else $error("pready low");
  a_unmapped_err: assert property (psel_i && penable_i && bad_a |-> pslverr_o)
    else $error("no error on unmapped access");
  a_mapped_ok: assert property (psel_i && penable_i && !bad_a |-> !pslverr_o)
    else $error("error on mapped access");
  a_unmapped_zero: assert property (psel_i && penable_i && !pwrite_i && bad_a |->
    prdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  // even the shortest period keeps pulses far apart
  a_reset_spacing: assert property (device_reset_o |=> !device_reset_o [*8])
    else $error("device reset pulses too close");
  a_wake_spacing: assert property (pc_stack_reset_o |=> !pc_stack_reset_o [*8])
    else $error("pc reset pulses too close");
  a_pulse_excl: assert property (!(device_reset_o && pc_stack_reset_o))
    else $error("both reset kinds at once");
  a_run_reset: assert property (device_reset_o |->
    $past(power_mode_o) == wdt_pkg::MODE_RUN)
    else $error("device reset outside run");
  a_low_power_reset: assert property (pc_stack_reset_o |->
    $past(power_mode_o) != wdt_pkg::MODE_RUN)
    else $error("pc reset while running");
  a_core_clock_mode: assert property (core_clock_run_o ==
    (power_mode_o inside {wdt_pkg::MODE_RUN, wdt_pkg::MODE_IDLE_ON}))
    else $error("core clock run wrong for mode");
  a_ext_reset_quiet: assert property (!ext_reset_n_i ##1 !ext_reset_n_i |=>
    !device_reset_o && !pc_stack_reset_o)
    else $error("timeout right after reset pin");
  c_dev_reset: cover property (device_reset_o);
  c_pc_reset: cover property (pc_stack_reset_o);
  c_idle_off: cover property (power_mode_o == wdt_pkg::MODE_IDLE_OFF);
endmodule
bind watchdog_timer watchdog_timer_chk chk (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .ext_reset_n_i, .device_reset_o,
  .pc_stack_reset_o, .core_clock_run_o, .power_mode_o);
